// >>> core/trc_regs.vh
/*
 * Constants for the terminal run-command decoder and analog scaler.
 * Assumes a 100 MHz system clock and the numeric units listed below.
 */
// Function
// - Two-wire 1: forward alone runs forward, reverse alone reverse, both or none stop.
// - Two-wire 2: first terminal runs, second picks reverse; first off stops.
// - Two-wire schemes act on present terminal levels, not on edges.
// - Three-wire 1: run requests are accepted only while enable is on.
// - Three-wire 1: enable going off stops the motor.
// - Three-wire 1: direction terminals start on a pulse; enable is a level.
// - Three-wire 2: run pulse starts while enabled; direction 0 forward, 1 reverse.
// - Three-wire 2: enable going off stops the motor.
// - Three-wire 2: run terminal is edge-triggered; direction and enable are levels.
// - UP/DOWN ramps the frequency reference at a programmable Hz/s rate.
// - Rate unit is 0.001 Hz/s at resolution 2, 0.01 Hz/s at resolution 1.
// - Curve one maps linearly between min and max points, defaults 0V/0%, 10V/100%.
// - Input above maximum point clamps to the maximum point's value.
// - Input below minimum point gives minimum value or 0.0% per input selection.
// - Current inputs: 20 mA counts as 5 V, 4 mA as 1 V.
// - Each input is filtered with time constant 0.00 to 10.00 s, default 0.10 s.
// - Curve two defaults to 0.00 V/0.0% and 10.00 V/100.0%, filter 0.10 s.
// - Curve three defaults to -10.00 V/-100.0% and 10.00 V/100.0%.
// - Command mode 0..3 selects two-wire 1, two-wire 2, three-wire 1, three-wire 2.
// - Below-minimum selection 1 reads 0.0%; 0 uses the minimum-point value.
`ifndef TRC_REGS_VH
`define TRC_REGS_VH

// Command modes
`define TRC_MODE_2W1          2'h0
`define TRC_MODE_2W2          2'h1
`define TRC_MODE_3W1          2'h2
`define TRC_MODE_3W2          2'h3

// Reference resolution codes
`define TRC_RES_FINE          2'h2

// Timing: sample tick in microseconds, clock in MHz
`define TRC_CLK_MHZ           100
`define TRC_SAMPLE_US         1000
// Filter time unit is 10 ms, so ticks per unit is 10000 us / sample period
`define TRC_FILT_UNIT_US      10000

// UP/DOWN: micro-hertz added per tick per rate unit at coarse resolution
`define TRC_RES_COARSE_SCALE  32'h0000000A

// Curve selection codes 1..3
`define TRC_CURVE_SEL2        2'h2
`define TRC_CURVE_SEL3        2'h3
`define TRC_CURVE_IDX1        2'h0
`define TRC_CURVE_IDX2        2'h1
`define TRC_CURVE_IDX3        2'h2

// Voltage in 0.01 V, percent in 0.1 %, filter time in 0.01 s
`define TRC_V_ZERO            16'h0000
`define TRC_V_10              16'h03E8
`define TRC_V_NEG10           16'hFC18
`define TRC_PCT_ZERO          16'h0000
`define TRC_PCT_100           16'h03E8
`define TRC_PCT_NEG100        16'hFC18
`define TRC_FILT_DEF          16'h000A
`define TRC_FILT_MAX          16'h03E8

// Current in 0.01 mA becomes 0.01 V by dividing by four
`define TRC_MA_TO_V_SHIFT     2

// Filter accumulator fraction
`define TRC_FRAC_ZERO         16'h0000

`endif

// >>> core/trc_curve.v
/*
 * One analog channel: two-point curve with clamping and below-minimum
 * handling, then a first-order low-pass filter stepped on a sample tick.
 * Assumes the parent keeps min input at or below max input.
 */
`timescale 1ns/1ps
`default_nettype none
`include "trc_regs.vh"

module trc_curve #(
    parameter TICKS_PER_UNIT = `TRC_FILT_UNIT_US / `TRC_SAMPLE_US
) (
    input  wire               i_clk_sys,
    input  wire               i_arst_n,
    input  wire               i_tick,
    input  wire signed [15:0] i_x,
    input  wire signed [15:0] i_min_in,
    input  wire signed [15:0] i_min_out,
    input  wire signed [15:0] i_max_in,
    input  wire signed [15:0] i_max_out,
    input  wire        [15:0] i_filt,
    input  wire               i_below_zero,
    output reg  signed [15:0] o_y
);

    localparam [15:0] TPU = TICKS_PER_UNIT;

    reg signed [16:0] dx;
    reg signed [16:0] dy;
    reg signed [16:0] den;
    reg signed [33:0] prod;
    reg signed [33:0] quot;
    reg signed [15:0] target;
    reg signed [31:0] acc_q;
    reg signed [31:0] acc_d;
    reg signed [32:0] diff;
    reg signed [32:0] step;
    reg        [31:0] n_ticks;

    ////////////////////////////////////////////////////////////////////////////
    always @* begin
        dx     = {i_x[15], i_x} - {i_min_in[15], i_min_in};
        dy     = {i_max_out[15], i_max_out} - {i_min_out[15], i_min_out};
        den    = {i_max_in[15], i_max_in} - {i_min_in[15], i_min_in};
        prod   = dx * dy;
        quot   = {34{1'b0}};
        target = i_max_out;
        if (i_x > i_max_in) begin
            target = i_max_out;
        end else if (i_x < i_min_in) begin
            target = i_below_zero ? `TRC_PCT_ZERO : i_min_out;
        end else if (den == 17'sh00000) begin
            target = i_max_out;
        end else begin
            quot   = prod / den;
            target = i_min_out + quot[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Division keeps the time constant exact; a shift would only allow powers of two
    always @* begin
        n_ticks = i_filt * TPU;
        diff    = {target[15], target, `TRC_FRAC_ZERO} - {acc_q[31], acc_q};
        step    = diff / $signed({1'b0, n_ticks});
        if (n_ticks <= 32'h00000001) begin
            acc_d = {target, `TRC_FRAC_ZERO};
        end else begin
            acc_d = acc_q + step[31:0];
        end
    end

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            acc_q <= 32'h00000000;
            o_y   <= 16'h0000;
        end else if (i_tick) begin
            acc_q <= acc_d;
            o_y   <= acc_d[31:16];
        end
    end

endmodule // trc_curve

`default_nettype wire

// >>> core/trc_terminal_ctrl.v
/*
 * Terminal run-command decoder, UP/DOWN frequency ramp and analog scaler
 * for two analog inputs over three programmable two-point curves.
 * Assumes terminal inputs are already synchronous and debounced.
 */
`timescale 1ns/1ps
`default_nettype none
`include "trc_regs.vh"

module trc_terminal_ctrl #(
    parameter SAMPLE_CYCLES = `TRC_SAMPLE_US * `TRC_CLK_MHZ,
    parameter [31:0] MAX_FREQ_UHZ = 32'h02FAF080
) (
    input  wire        i_clk_sys,
    input  wire        i_arst_n,
    input  wire [1:0]  i_cmd_mode,
    input  wire        i_fwd_term,
    input  wire        i_rev_term,
    input  wire        i_enable_term,
    input  wire        i_up,
    input  wire        i_down,
    input  wire [15:0] i_updown_rate,
    input  wire [1:0]  i_ref_resolution,
    input  wire        i_cfg_we,
    input  wire [1:0]  i_cfg_curve,
    input  wire [15:0] i_cfg_min_in,
    input  wire [15:0] i_cfg_min_out,
    input  wire [15:0] i_cfg_max_in,
    input  wire [15:0] i_cfg_max_out,
    input  wire [15:0] i_cfg_filt,
    input  wire [15:0] i_analog_v,
    input  wire [15:0] i_analog_c,
    input  wire [1:0]  i_curve_sel_v,
    input  wire [1:0]  i_curve_sel_c,
    input  wire [1:0]  i_below_min_sel,
    output reg         o_run,
    output reg         o_reverse,
    output reg  [31:0] o_freq_ref,
    output wire [15:0] o_analog_v_pct,
    output wire [15:0] o_analog_c_pct
);

    localparam [31:0] TICK_LAST = SAMPLE_CYCLES - 1;

    localparam [2:0] ST_STOP = 3'b001;
    localparam [2:0] ST_FWD  = 3'b010;
    localparam [2:0] ST_REV  = 3'b100;

    // Selection codes outside 1..3 fall back to curve one
    function [1:0] curve_idx;
        input [1:0] sel;
        begin
            case (sel)
                `TRC_CURVE_SEL2: curve_idx = `TRC_CURVE_IDX2;
                `TRC_CURVE_SEL3: curve_idx = `TRC_CURVE_IDX3;
                default:         curve_idx = `TRC_CURVE_IDX1;
            endcase
        end
    endfunction

    function curve_ok;
        input [1:0] idx;
        begin
            curve_ok = (idx == `TRC_CURVE_IDX1) || (idx == `TRC_CURVE_IDX2) ||
                       (idx == `TRC_CURVE_IDX3);
        end
    endfunction

    reg [31:0] tick_cnt_q;
    reg        tick_q;
    reg [2:0]  state_q;
    reg [2:0]  state_d;
    reg        fwd_prev_q;
    reg        rev_prev_q;
    wire       fwd_rise;
    wire       rev_rise;
    reg [31:0] step;
    reg [31:0] freq_d;

    reg [15:0] min_in_q  [0:2];
    reg [15:0] min_out_q [0:2];
    reg [15:0] max_in_q  [0:2];
    reg [15:0] max_out_q [0:2];
    reg [15:0] filt_q    [0:2];

    wire [1:0]  cfg_idx;
    wire [1:0]  idx_v;
    wire [1:0]  idx_c;
    wire [15:0] analog_c_volt;

    ////////////////////////////////////////////////////////////////////////////
    // Sample tick shared by ramp and filters
    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_cnt_q <= 32'h00000000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q >= TICK_LAST) begin
            tick_cnt_q <= 32'h00000000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
            tick_q     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Run command decoding
    assign fwd_rise = i_fwd_term & ~fwd_prev_q;
    assign rev_rise = i_rev_term & ~rev_prev_q;

    always @* begin
        state_d = state_q;
        case (i_cmd_mode)
            `TRC_MODE_2W1: begin
                // Both on counts as stop, not as a conflict
                if (i_fwd_term && !i_rev_term) begin
                    state_d = ST_FWD;
                end else if (i_rev_term && !i_fwd_term) begin
                    state_d = ST_REV;
                end else begin
                    state_d = ST_STOP;
                end
            end
            `TRC_MODE_2W2: begin
                if (!i_fwd_term) begin
                    state_d = ST_STOP;
                end else if (i_rev_term) begin
                    state_d = ST_REV;
                end else begin
                    state_d = ST_FWD;
                end
            end
            `TRC_MODE_3W1: begin
                if (!i_enable_term) begin
                    state_d = ST_STOP;
                end else if (fwd_rise) begin
                    state_d = ST_FWD;
                end else if (rev_rise) begin
                    state_d = ST_REV;
                end
            end
            `TRC_MODE_3W2: begin
                if (!i_enable_term) begin
                    state_d = ST_STOP;
                end else if (fwd_rise || (state_q != ST_STOP)) begin
                    state_d = i_rev_term ? ST_REV : ST_FWD;
                end
            end
            default: begin
                state_d = ST_STOP;
            end
        endcase
    end

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q    <= ST_STOP;
            fwd_prev_q <= 1'b0;
            rev_prev_q <= 1'b0;
            o_run      <= 1'b0;
            o_reverse  <= 1'b0;
        end else begin
            state_q    <= state_d;
            fwd_prev_q <= i_fwd_term;
            rev_prev_q <= i_rev_term;
            o_run      <= (state_d != ST_STOP);
            o_reverse  <= (state_d == ST_REV);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // UP/DOWN ramp; the reference is kept in micro-hertz so fine rates accumulate
    always @* begin
        if (i_ref_resolution == `TRC_RES_FINE) begin
            step = {16'h0000, i_updown_rate};
        end else begin
            step = {16'h0000, i_updown_rate} * `TRC_RES_COARSE_SCALE;
        end
        freq_d = o_freq_ref;
        if (i_up && !i_down) begin
            if (MAX_FREQ_UHZ - o_freq_ref < step) begin
                freq_d = MAX_FREQ_UHZ;
            end else begin
                freq_d = o_freq_ref + step;
            end
        end else if (i_down && !i_up) begin
            if (o_freq_ref < step) begin
                freq_d = 32'h00000000;
            end else begin
                freq_d = o_freq_ref - step;
            end
        end
    end

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_freq_ref <= 32'h00000000;
        end else if (tick_q) begin
            o_freq_ref <= freq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Curve settings; defaults per curve at reset
    assign cfg_idx = i_cfg_curve;

    always @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            min_in_q[`TRC_CURVE_IDX1]  <= `TRC_V_ZERO;
            min_out_q[`TRC_CURVE_IDX1] <= `TRC_PCT_ZERO;
            max_in_q[`TRC_CURVE_IDX1]  <= `TRC_V_10;
            max_out_q[`TRC_CURVE_IDX1] <= `TRC_PCT_100;
            filt_q[`TRC_CURVE_IDX1]    <= `TRC_FILT_DEF;
            min_in_q[`TRC_CURVE_IDX2]  <= `TRC_V_ZERO;
            min_out_q[`TRC_CURVE_IDX2] <= `TRC_PCT_ZERO;
            max_in_q[`TRC_CURVE_IDX2]  <= `TRC_V_10;
            max_out_q[`TRC_CURVE_IDX2] <= `TRC_PCT_100;
            filt_q[`TRC_CURVE_IDX2]    <= `TRC_FILT_DEF;
            min_in_q[`TRC_CURVE_IDX3]  <= `TRC_V_NEG10;
            min_out_q[`TRC_CURVE_IDX3] <= `TRC_PCT_NEG100;
            max_in_q[`TRC_CURVE_IDX3]  <= `TRC_V_10;
            max_out_q[`TRC_CURVE_IDX3] <= `TRC_PCT_100;
            filt_q[`TRC_CURVE_IDX3]    <= `TRC_FILT_DEF;
        end else if (i_cfg_we && curve_ok(cfg_idx)) begin
            // Pulling min down to max keeps the slope denominator non-negative
            if ($signed(i_cfg_min_in) > $signed(i_cfg_max_in)) begin
                min_in_q[cfg_idx] <= i_cfg_max_in;
            end else begin
                min_in_q[cfg_idx] <= i_cfg_min_in;
            end
            min_out_q[cfg_idx] <= i_cfg_min_out;
            max_in_q[cfg_idx]  <= i_cfg_max_in;
            max_out_q[cfg_idx] <= i_cfg_max_out;
            if (i_cfg_filt > `TRC_FILT_MAX) begin
                filt_q[cfg_idx] <= `TRC_FILT_MAX;
            end else begin
                filt_q[cfg_idx] <= i_cfg_filt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog channels
    assign idx_v = curve_idx(i_curve_sel_v);
    assign idx_c = curve_idx(i_curve_sel_c);
    assign analog_c_volt = i_analog_c >> `TRC_MA_TO_V_SHIFT;

    trc_curve u_curve_v (
        .i_clk_sys    (i_clk_sys),
        .i_arst_n     (i_arst_n),
        .i_tick       (tick_q),
        .i_x          (i_analog_v),
        .i_min_in     (min_in_q[idx_v]),
        .i_min_out    (min_out_q[idx_v]),
        .i_max_in     (max_in_q[idx_v]),
        .i_max_out    (max_out_q[idx_v]),
        .i_filt       (filt_q[idx_v]),
        .i_below_zero (i_below_min_sel[0]),
        .o_y          (o_analog_v_pct)
    );

    trc_curve u_curve_c (
        .i_clk_sys    (i_clk_sys),
        .i_arst_n     (i_arst_n),
        .i_tick       (tick_q),
        .i_x          (analog_c_volt),
        .i_min_in     (min_in_q[idx_c]),
        .i_min_out    (min_out_q[idx_c]),
        .i_max_in     (max_in_q[idx_c]),
        .i_max_out    (max_out_q[idx_c]),
        .i_filt       (filt_q[idx_c]),
        .i_below_zero (i_below_min_sel[1]),
        .o_y          (o_analog_c_pct)
    );

endmodule // trc_terminal_ctrl

`default_nettype wire

// >>> dv/trc_props.sv
/*
 * Port checker for trc_terminal_ctrl: run decoding and ramp relations.
 * Assumes one clock domain; attached to every instance by the bind below.
 */
`timescale 1ns/1ps
`default_nettype none
module trc_props #(
    parameter [31:0] MAX_FREQ_UHZ = 32'h02FAF080
) (
    input wire logic        i_clk_sys,
    input wire logic        i_arst_n,
    input wire logic [1:0]  i_cmd_mode,
    input wire logic        i_fwd_term,
    input wire logic        i_rev_term,
    input wire logic        i_enable_term,
    input wire logic        i_up,
    input wire logic        i_down,
    input wire logic        o_run,
    input wire logic        o_reverse,
    input wire logic [31:0] o_freq_ref
);
    default clocking dc @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////////////////////////////////////////////////
    AST_2W1_FWD: assert property (
        i_cmd_mode == 2'h0 && i_fwd_term && !i_rev_term |=> o_run && !o_reverse)
        else $error("two-wire 1 forward not decoded");
    AST_2W1_STOP: assert property (
        i_cmd_mode == 2'h0 && i_fwd_term == i_rev_term |=> !o_run)
        else $error("two-wire 1 stop not decoded");
    AST_2W2_MAP: assert property (
        i_cmd_mode == 2'h1 |=> o_run == $past(i_fwd_term)
            && o_reverse == ($past(i_fwd_term) && $past(i_rev_term)))
        else $error("two-wire 2 decode wrong");
    AST_3W_EN_OFF: assert property (
        i_cmd_mode[1] && !i_enable_term |=> !o_run)
        else $error("three-wire run without enable");
    AST_3W1_FWD: assert property (
        $past(i_arst_n) && i_cmd_mode == 2'h2 && i_enable_term && $rose(i_fwd_term)
            |=> o_run && !o_reverse)
        else $error("three-wire 1 forward pulse ignored");
    AST_3W1_HOLD: assert property (
        $past(i_arst_n) && i_cmd_mode == 2'h2 && $stable(i_cmd_mode) && i_enable_term
            && !$rose(i_fwd_term) && !$rose(i_rev_term) |=> $stable(o_run) && $stable(o_reverse))
        else $error("three-wire 1 state moved without a pulse");
    AST_3W2_START: assert property (
        $past(i_arst_n) && i_cmd_mode == 2'h3 && i_enable_term && $rose(i_fwd_term)
            |=> o_run && o_reverse == $past(i_rev_term))
        else $error("three-wire 2 run pulse ignored");
    AST_3W2_DIR: assert property (
        i_cmd_mode == 2'h3 && i_enable_term && o_run |=> o_run && o_reverse == $past(i_rev_term))
        else $error("three-wire 2 direction not tracked");
    AST_RAMP_CAUSE: assert property (
        $changed(o_freq_ref) |-> $past(i_up) != $past(i_down)
            || $past(i_up, 2) != $past(i_down, 2) || $past(i_up, 3) != $past(i_down, 3))
        else $error("reference moved without up or down");
    AST_RAMP_MAX: assert property (
        o_freq_ref <= MAX_FREQ_UHZ)
        else $error("reference above ceiling");
endmodule // trc_props
bind trc_terminal_ctrl trc_props #(.MAX_FREQ_UHZ(MAX_FREQ_UHZ)) u_props (.*);
`default_nettype wire

// >>> dv/trc_switch_model.sv
/*
 * Model of the switches and push buttons wired to the run terminals.
 * Assumes the bench calls its tasks; all changes land on a falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module trc_switch_model (
    input  wire logic i_clk_sys,
    output var logic  o_fwd,
    output var logic  o_rev,
    output var logic  o_en
);
    initial begin
        o_fwd = 1'b0;
        o_rev = 1'b0;
        o_en  = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////////
    // Maintained contacts; opening enable is the only three-wire stop
    task automatic set_levels(input logic f, input logic r, input logic e);
        @(negedge i_clk_sys);
        o_fwd = f;
        o_rev = r;
        o_en  = e;
    endtask
    // Momentary button: held three cycles, then back to open
    task automatic press(input logic reverse_input);
        @(negedge i_clk_sys);
        o_fwd = o_fwd | !reverse_input;
        o_rev = o_rev | reverse_input;
        repeat (3) @(negedge i_clk_sys);
        o_fwd = o_fwd & reverse_input;
        o_rev = o_rev & !reverse_input;
    endtask
endmodule // trc_switch_model
`default_nettype wire

// >>> dv/tb_top.sv
/*
 * Self-checking bench for trc_terminal_ctrl: schemes, ramp and curves.
 * Assumes a short sample tick so filter and ramp times shrink alike.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int SC = 10;
    logic        i_clk_sys = 1'b0;
    logic        i_arst_n = 1'b0;
    logic [1:0]  i_cmd_mode = 2'h0;
    logic        i_fwd_term, i_rev_term, i_enable_term;
    logic        i_up = 1'b0, i_down = 1'b0, i_cfg_we = 1'b0;
    logic [1:0]  i_ref_resolution = 2'h1, i_cfg_curve = 2'h0, i_below_min_sel = 2'h0;
    logic [1:0]  i_curve_sel_v = 2'h2, i_curve_sel_c = 2'h3;
    logic [15:0] i_updown_rate = 16'h0064, i_cfg_min_in = 16'h0000, i_cfg_min_out = 16'h0000;
    logic [15:0] i_cfg_max_in = 16'h0000, i_cfg_max_out = 16'h0000, i_cfg_filt = 16'h0000;
    logic [15:0] i_analog_v = 16'h0000, i_analog_c = 16'h0000;
    logic        o_run, o_reverse;
    logic [31:0] o_freq_ref;
    logic [15:0] o_analog_v_pct, o_analog_c_pct;
    int          errors = 0, check_count = 0, cyc_cnt = 0;

    trc_terminal_ctrl #(.SAMPLE_CYCLES(SC), .MAX_FREQ_UHZ(32'h00000064)) i_dut (.*);
    trc_switch_model u_sw (
        .i_clk_sys (i_clk_sys),
        .o_fwd     (i_fwd_term),
        .o_rev     (i_rev_term),
        .o_en      (i_enable_term)
    );
    always #5 i_clk_sys = ~i_clk_sys;
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
        end
    endtask
    // Filtered outputs only approach their target
    function automatic logic near(input logic [15:0] a, input int e);
        return ($signed(a) - e <= 2) && (e - $signed(a) <= 2);
    endfunction
    task automatic cfg(input logic [1:0] c, input int mi, input int mo, input int xi, input int xo);
        i_cfg_curve = c;
        i_cfg_min_in = mi[15:0];
        i_cfg_min_out = mo[15:0];
        i_cfg_max_in = xi[15:0];
        i_cfg_max_out = xo[15:0];
        i_cfg_filt = 16'h0000;
        i_cfg_we = 1'b1;
        cyc(1);
        i_cfg_we = 1'b0;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic t_two_wire;
        logic f, r;
        for (int m = 0; m < 2; m++) begin
            i_cmd_mode = m[1:0];
            for (int k = 0; k < 4; k++) begin
                f = k[0];
                r = k[1];
                u_sw.set_levels(f, r, 1'b0);
                cyc(2);
                check(o_run, m ? f : f ^ r, "run");
                check(o_reverse, m ? f & r : r & !f, "dir");
            end
        end
        $display("done two_wire");
    endtask
    task automatic t_three_wire;
        i_cmd_mode = 2'h2;
        u_sw.set_levels(1'b0, 1'b0, 1'b0);
        u_sw.press(1'b0);
        cyc(1);
        check(o_run, 1'b0, "3w1 pulse while disabled");
        u_sw.set_levels(1'b0, 1'b0, 1'b1);
        u_sw.press(1'b0);
        cyc(2);
        check({o_run, o_reverse}, 2'b10, "3w1 forward kept");
        u_sw.press(1'b1);
        check({o_run, o_reverse}, 2'b11, "3w1 reverse");
        u_sw.set_levels(1'b0, 1'b0, 1'b0);
        cyc(2);
        check(o_run, 1'b0, "3w1 stop");
        i_cmd_mode = 2'h3;
        u_sw.set_levels(1'b0, 1'b1, 1'b1);
        u_sw.press(1'b0);
        check({o_run, o_reverse}, 2'b11, "3w2 start reverse");
        u_sw.set_levels(1'b0, 1'b0, 1'b1);
        cyc(2);
        check({o_run, o_reverse}, 2'b10, "3w2 forward level");
        u_sw.set_levels(1'b1, 1'b0, 1'b0);
        cyc(2);
        check(o_run, 1'b0, "3w2 stop");
        u_sw.set_levels(1'b1, 1'b0, 1'b1);
        cyc(2);
        check(o_run, 1'b0, "3w2 held level");
        u_sw.set_levels(1'b0, 1'b0, 1'b0);
        $display("done three_wire");
    endtask
    // Exactly ticks*SC sampled edges hold exactly that many ticks
    task automatic ud(input logic u, input logic d, input logic [1:0] res, input int rate,
                      input int ticks, input int exp);
        i_up = u;
        i_down = d;
        i_ref_resolution = res;
        i_updown_rate = rate[15:0];
        cyc(ticks * SC);
        i_up = 1'b0;
        i_down = 1'b0;
        cyc(5);
        check(o_freq_ref, exp, "ramp");
    endtask
    task automatic t_ramp;
        ud(1'b1, 1'b0, 2'h1, 3, 3, 90);
        ud(1'b1, 1'b0, 2'h2, 7, 1, 97);
        ud(1'b1, 1'b0, 2'h2, 7, 2, 100);
        ud(1'b1, 1'b1, 2'h2, 7, 3, 100);
        ud(1'b0, 1'b1, 2'h1, 3, 5, 0);
        $display("done ramp");
    endtask
    task automatic t_curve_defaults;
        i_analog_v = 16'h01F4;
        i_analog_c = 16'h07D0;
        cyc(5 * SC);
        check($signed(o_analog_v_pct) < 400, 1'b1, "filter too fast");
        cyc(800 * SC);
        check(near(o_analog_v_pct, 500), 1'b1, "curve2 default");
        check(near(o_analog_c_pct, 500), 1'b1, "curve3 current");
        i_curve_sel_v = 2'h3;
        i_curve_sel_c = 2'h1;
        i_analog_v = 16'hFC18;
        cyc(800 * SC);
        check(near(o_analog_v_pct, -1000), 1'b1, "curve3 default");
        check(near(o_analog_c_pct, 500), 1'b1, "curve1 default");
        $display("done curve_defaults");
    endtask
    task automatic t_curve_custom;
        int xs [6] = '{100, 100, 200, 500, 800, 900};
        int bs [6] = '{0, 1, 0, 0, 0, 0};
        int es [6] = '{100, 0, 100, -200, -500, -500};
        i_curve_sel_v = 2'h1;
        cfg(2'h0, 200, 100, 800, -500);
        for (int k = 0; k < 6; k++) begin
            i_analog_v = xs[k][15:0];
            i_below_min_sel = {1'b0, bs[k][0]};
            cyc(3 * SC);
            check(o_analog_v_pct, es[k][15:0], "map");
        end
        i_analog_c = 16'h0640;
        i_below_min_sel = 2'h2;
        cyc(3 * SC);
        check(o_analog_c_pct, 16'hFF9C, "current map");
        i_analog_c = 16'h0190;
        cyc(3 * SC);
        check(o_analog_c_pct, 16'h0000, "current below");
        cfg(2'h0, 900, 100, 300, -500);
        i_analog_v = 16'h012C;
        cyc(3 * SC);
        check(o_analog_v_pct, 16'hFE0C, "min above max");
        $display("done curve_custom");
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 25000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        repeat (6) @(negedge i_clk_sys);
        i_arst_n = 1'b1;
        cyc(2);
        check({o_run, o_reverse}, 2'b00, "reset run state");
        check(o_freq_ref, 32'h00000000, "reset reference");
        t_two_wire();
        t_three_wire();
        t_ramp();
        t_curve_defaults();
        t_curve_custom();
        test_done();
    end
endmodule // tb_top
`default_nettype wire
